// [bench/line_ident_regs_props.sv]
// Assertions on the register bank ports
module line_ident_regs_props
  import line_ident_pkg::*;
#(parameter int CHECK_LEN = CHECK_CYCLES) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic part_ok,
  input wire logic legacy_rx_boost,
  input wire logic legacy_tx_cut,
  input wire logic [2:0] rx_gain_field,
  input wire logic [2:0] tx_atten_field,
  input wire logic rx_mute,
  input wire logic tx_mute,
  input wire logic check_running,
  input wire logic data_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata");
  a_val_read: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_VALIDATION |->
    reg_rdata[7:3] == 5'h00 && reg_rdata[1] == $past(check_running)) else $error("validation");
  a_check_len: assert property ($rose(check_running) |-> ##CHECK_LEN $fell(check_running))
    else $error("check length");
  a_result_gate: assert property ($fell(check_running) |-> data_enable == $past(part_ok))
    else $error("result");
  a_no_early_data: assert property (check_running |-> !data_enable) else $error("early");
  a_gate_hold: assert property (!check_running && $stable(check_running) |-> $stable(data_enable))
    else $error("gate moved");
  a_legacy_wr: assert property (reg_wr && reg_addr == ADDR_IDENT_GAIN |=>
    {legacy_rx_boost, legacy_tx_cut} == $past(reg_wdata[1:0])) else $error("legacy");
  a_gain_wr: assert property (reg_wr && reg_addr == ADDR_GAIN_CTRL |=>
    {tx_mute, tx_atten_field, rx_mute, rx_gain_field} == $past(reg_wdata)) else $error("gain");
endmodule
bind line_ident_regs line_ident_regs_props #(
  .CHECK_LEN(CHECK_LEN)
) u_props (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .part_ok(part_ok),
  .legacy_rx_boost(legacy_rx_boost),
  .legacy_tx_cut(legacy_tx_cut),
  .rx_gain_field(rx_gain_field),
  .tx_atten_field(tx_atten_field),
  .rx_mute(rx_mute),
  .tx_mute(tx_mute),
  .check_running(check_running),
  .data_enable(data_enable)
);

// [bench/line_side_model.sv]
// Line-side chip model: variant, revision, identity
module line_side_model (
  input wire logic [3:0] rev_set,
  input wire logic intl,
  input wire logic genuine,
  output logic line_variant_bit,
  output logic [3:0] line_chip_revision,
  output logic part_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  assign line_variant_bit = intl;
  assign line_chip_revision = rev_set;
  assign part_ok = genuine;
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the line-side register bank
module tb_top;
  import line_ident_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, line_enable = 0, intl = 0, genuine = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, w;
  logic [3:0] rev_set = 4'h0, lrev;
  logic [2:0] rxg, txa;
  logic rxb, txc, rxm, txm, running, data_enable, lv, ok;
  int err_count = 0, n_checks = 0, seed = 49, cyc = 0;
  line_side_model far (.rev_set(rev_set), .intl(intl), .genuine(genuine),
    .line_variant_bit(lv), .line_chip_revision(lrev), .part_ok(ok));
  line_ident_regs #(.CHECK_LEN(4)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .line_enable(line_enable), .line_variant_bit(lv), .line_chip_revision(lrev), .part_ok(ok),
    .legacy_rx_boost(rxb), .legacy_tx_cut(txc), .rx_gain_field(rxg), .tx_atten_field(txa),
    .rx_mute(rxm), .tx_mute(txm), .check_running(running), .data_enable(data_enable));
  function automatic logic [7:0] ident_exp(input logic [7:0] d);
    return {1'b0, d[7], d[5:2], d[1:0]};
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // One check per reset, so each outcome needs its own reset
  task run_check(input logic good);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    line_enable <= 1'b0;
    genuine <= good;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    line_enable <= 1'b1;
    rd(ADDR_VALIDATION, 8'h06);
    chk({7'h00, running}, 8'h01);
    repeat (6) @(posedge clk_sys);
    rd(ADDR_VALIDATION, {7'h00, ~good});
    chk({7'h00, data_enable}, {7'h00, good});
    chk({7'h00, running}, 8'h00);
    @(posedge clk_sys);
    line_enable <= 1'b0;
    @(posedge clk_sys);
    line_enable <= 1'b1;
    rd(ADDR_VALIDATION, {7'h00, ~good});
    wr(ADDR_GAIN_CTRL, 8'h5a);
    rd(ADDR_GAIN_CTRL, 8'h5a);
    $display("check test done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(ADDR_VALIDATION, VALIDATION_RESET);
    rd(ADDR_GAIN_CTRL, GAIN_CTRL_RESET);
    rd(8'h0c, 8'h00);
    for (int i = 0; i < 24; i++) begin
      w = (i == 0) ? 8'hff : 8'($random(seed));
      wr(ADDR_GAIN_CTRL, 8'h00);
      intl <= w[7];
      rev_set <= w[5:2];
      wr(ADDR_IDENT_GAIN, w);
      rd(ADDR_IDENT_GAIN, ident_exp(w));
      chk({6'h00, rxb, txc}, {6'h00, w[1:0]});
      wr(ADDR_IDENT_GAIN, w & 8'hfc);
      wr(ADDR_VALIDATION, w);
      wr(ADDR_GAIN_CTRL, ~w);
      rd(ADDR_VALIDATION, VALIDATION_RESET);
      rd(ADDR_GAIN_CTRL, ~w);
      chk({txm, txa, rxm, rxg}, ~w);
      chk({6'h00, rxb, txc}, 8'h00);
    end
    $display("register test done");
    run_check(1'b1);
    run_check(1'b0);
    finish_test;
  end
endmodule

// [core/line_check_fsm.sv]
// Automatic line-side part verification sequencer
module line_check_fsm
  import line_ident_pkg::*;
#(
  parameter int CYCLES = CHECK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic line_enable,
  input wire logic part_ok,
  output logic pending,
  output logic running,
  output logic bad_part
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } check_state_t;

  check_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic bad_reg;

  // One check per reset: re-enabling the line side does not recheck
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: if (line_enable) state_reg <= ST_RUN;
        ST_RUN: if (cnt_reg == CNT_W'(CYCLES - 1)) state_reg <= ST_DONE;
        default: state_reg <= state_reg;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (state_reg == ST_RUN) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // Result is sampled as the check ends
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bad_reg <= 1'b0;
    end else if (state_reg == ST_RUN && cnt_reg == CNT_W'(CYCLES - 1)) begin
      bad_reg <= ~part_ok;
    end
  end

  assign pending = (state_reg != ST_DONE);
  assign running = (state_reg == ST_RUN);
  assign bad_part = bad_reg;
endmodule

// [core/line_ident_pkg.sv]
// Constants for the line-side identification and validation registers
package line_ident_pkg;
  localparam logic [7:0] ADDR_IDENT_GAIN = 8'h0d;
  localparam logic [7:0] ADDR_VALIDATION = 8'h0e;
  localparam logic [7:0] ADDR_GAIN_CTRL = 8'h0f;
  localparam int VARIANT_BIT = 6;
  localparam int REV_HI = 5;
  localparam int REV_LO = 2;
  localparam int RX_BOOST_BIT = 1;
  localparam int TX_CUT_BIT = 0;
  localparam int PENDING_BIT = 2;
  localparam int RUNNING_BIT = 1;
  localparam int RESULT_BIT = 0;
  localparam logic [7:0] VALIDATION_RESET = 8'h04;
  localparam logic [7:0] GAIN_CTRL_RESET = 8'h00;
  localparam logic [1:0] LEGACY_RESET = 2'h0;
  // Check duration in ns, and its cycle count at 5 ns per cycle
  localparam int CHECK_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CHECK_CYCLES = (CHECK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
endpackage

// [core/line_ident_regs.sv]
// Identification, legacy gain and validation register bank
// Contract
// - Ident holds domestic/international variant bit
// - Ident reports read-only four-bit revision
// - Receive-boost bit adds 6 dB receive gain
// - Transmit-cut bit applies 3 dB attenuation
// - First enable starts automatic part check
// - Pending bit reads 1 until checked
// - Running bit reads 1 during check
// - Result 0 correct part, 1 wrong
// - Wrong part blocks data, registers still work
// - Validation register resets to 0x04
// - Gain and mute register resets to zero
module line_ident_regs
  import line_ident_pkg::*;
#(
  parameter int CHECK_LEN = CHECK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic line_enable,
  input wire logic line_variant_bit,
  input wire logic [3:0] line_chip_revision,
  input wire logic part_ok,
  output logic legacy_rx_boost,
  output logic legacy_tx_cut,
  output logic [2:0] rx_gain_field,
  output logic [2:0] tx_atten_field,
  output logic rx_mute,
  output logic tx_mute,
  output logic check_running,
  output logic data_enable
);
  logic ident_wr;
  logic gain_wr;

  logic ident_rd;
  logic val_rd;
  logic gain_rd;

  logic rx_boost_reg;
  logic tx_cut_reg;

  logic tx_mute_reg;
  logic [2:0] tx_atten_reg;
  logic rx_mute_reg;
  logic [2:0] rx_gain_reg;

  logic [7:0] ident_img;
  logic [7:0] val_img;
  logic [7:0] gain_img;
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;

  logic pending;
  logic bad_part;

  // Address decode is shared by the write path and the read path
  function automatic logic is_ident(
    input logic [7:0] addr
  );
    return addr == ADDR_IDENT_GAIN;
  endfunction

  function automatic logic is_validation(
    input logic [7:0] addr
  );
    return addr == ADDR_VALIDATION;
  endfunction

  function automatic logic is_gain(
    input logic [7:0] addr
  );
    return addr == ADDR_GAIN_CTRL;
  endfunction

  // Images start from zero so reserved positions never leak a value
  function automatic logic [7:0] ident_image(
    input logic variant,
    input logic [3:0] revision,
    input logic boost,
    input logic cut
  );
    logic [7:0] img;
    img = 8'h00;
    img[VARIANT_BIT] = variant;
    img[REV_HI:REV_LO] = revision;
    img[RX_BOOST_BIT] = boost;
    img[TX_CUT_BIT] = cut;
    return img;
  endfunction

  function automatic logic [7:0] validation_image(
    input logic chk_pending,
    input logic chk_running,
    input logic chk_bad
  );
    logic [7:0] img;
    img = 8'h00;
    img[PENDING_BIT] = chk_pending;
    img[RUNNING_BIT] = chk_running;
    img[RESULT_BIT] = chk_bad;
    return img;
  endfunction

  function automatic logic [7:0] gain_image(
    input logic txm,
    input logic [2:0] txa,
    input logic rxm,
    input logic [2:0] rxg
  );
    return {txm, txa, rxm, rxg};
  endfunction

  // The gate opens only once a finished check found the right part
  function automatic logic gate_open(
    input logic chk_pending,
    input logic chk_running,
    input logic chk_bad
  );
    return !chk_pending && !chk_running && !chk_bad;
  endfunction

  line_check_fsm #(
    .CYCLES(CHECK_LEN)
  ) u_check (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .line_enable(line_enable),
    .part_ok(part_ok),
    .pending(pending),
    .running(check_running),
    .bad_part(bad_part)
  );

  // Writes to the validation register or unmapped addresses decode to nothing
  assign ident_wr = reg_wr && is_ident(reg_addr);
  assign gain_wr = reg_wr && is_gain(reg_addr);
  assign ident_rd = reg_rd && is_ident(reg_addr);
  assign val_rd = reg_rd && is_validation(reg_addr);
  assign gain_rd = reg_rd && is_gain(reg_addr);

  // Only the two legacy bits of the ident register take writes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_boost_reg <= LEGACY_RESET[1];
    end else if (ident_wr) begin
      rx_boost_reg <= reg_wdata[RX_BOOST_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_cut_reg <= LEGACY_RESET[0];
    end else if (ident_wr) begin
      tx_cut_reg <= reg_wdata[TX_CUT_BIT];
    end
  end

  // Legacy bits and gain fields are stored apart; keeping them exclusive is up to software
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_mute_reg <= GAIN_CTRL_RESET[7];
    end else if (gain_wr) begin
      tx_mute_reg <= reg_wdata[7];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_atten_reg <= GAIN_CTRL_RESET[6:4];
    end else if (gain_wr) begin
      tx_atten_reg <= reg_wdata[6:4];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_mute_reg <= GAIN_CTRL_RESET[3];
    end else if (gain_wr) begin
      rx_mute_reg <= reg_wdata[3];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_gain_reg <= GAIN_CTRL_RESET[2:0];
    end else if (gain_wr) begin
      rx_gain_reg <= reg_wdata[2:0];
    end
  end

  assign ident_img = ident_image(
    line_variant_bit,
    line_chip_revision,
    rx_boost_reg,
    tx_cut_reg
  );
  assign val_img = validation_image(pending, check_running, bad_part);
  assign gain_img = gain_image(tx_mute_reg, tx_atten_reg, rx_mute_reg, rx_gain_reg);

  // Idle cycles and unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    if (ident_rd) begin
      rdata_next = ident_img;
    end else if (val_rd) begin
      rdata_next = val_img;
    end else if (gain_rd) begin
      rdata_next = gain_img;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign legacy_rx_boost = rx_boost_reg;
  assign legacy_tx_cut = tx_cut_reg;
  assign tx_mute = tx_mute_reg;
  assign tx_atten_field = tx_atten_reg;
  assign rx_mute = rx_mute_reg;
  assign rx_gain_field = rx_gain_reg;
  // Data flows only after a passing check; the bus is never gated
  assign data_enable = gate_open(pending, check_running, bad_part);
endmodule
